/* rtl/bpd_pkg.sv */
// Package for the self-test, power-down and pad-drive register bank.
// Assumes a 32-bit APB slave where each printed register index sits at byte address index * 4.
package bpd_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_RX_TEST_CTRL  = 8'h51;
  localparam logic [7:0] IDX_TX_I_SIG_HIGH = 8'h52;
  localparam logic [7:0] IDX_TX_I_SIG_LOW  = 8'h53;
  localparam logic [7:0] IDX_TX_Q_SIG_HIGH = 8'h54;
  localparam logic [7:0] IDX_TX_Q_SIG_LOW  = 8'h55;
  localparam logic [7:0] IDX_HW_REVISION   = 8'h5c;
  localparam logic [7:0] IDX_POWER_MAIN    = 8'h60;
  localparam logic [7:0] IDX_POWER_REGS    = 8'h61;
  localparam logic [7:0] IDX_REG_STATUS    = 8'h62;
  localparam logic [7:0] IDX_PAD_DRIVE     = 8'h63;
  localparam logic [7:0] IDX_RX_SIG_HIGH   = 8'h70;
  localparam logic [7:0] IDX_RX_SIG_LOW    = 8'h71;
  localparam logic [7:0] IDX_RX_TEST_STAT  = 8'h72;

  // Field positions.
  localparam int RX_ON_BIT      = 0;
  localparam int RX_START_BIT   = 1;
  localparam int RX_LOOP_BIT    = 2;
  localparam int RX_SOURCE_BIT  = 3;
  localparam int RX_PATTERN_BIT = 4;
  localparam int RES_SEL_BIT    = 0;
  localparam int REG_UP_LSB     = 3;
  localparam int DATA_PAD_LSB   = 6;
  localparam int IQ_PAD_LSB     = 4;

  // Writable masks; all other bits read as zero and ignore writes.
  localparam logic [7:0] RX_TEST_CTRL_MASK = 8'h1f;
  localparam logic [7:0] POWER_MAIN_MASK   = 8'hff;
  localparam logic [7:0] POWER_REGS_MASK   = 8'h7f;
  localparam logic [7:0] PAD_DRIVE_MASK    = 8'hf0;

  // Values after reset.
  localparam logic [7:0]  RX_TEST_CTRL_RST = 8'h00;
  localparam logic [7:0]  POWER_MAIN_RST   = 8'h00;
  localparam logic [7:0]  POWER_REGS_RST   = 8'h00;
  localparam logic        RES_SEL_RST      = 1'b0;
  localparam logic [7:0]  PAD_DRIVE_RST    = 8'h00;
  localparam logic [15:0] MISR_SEED        = 16'hffff;
  localparam logic [11:0] LFSR_SEED        = 12'h001;

  // Pad strength codes.
  localparam logic [1:0] PAD_4MA     = 2'h0;
  localparam logic [1:0] PAD_8MA     = 2'h1;
  localparam logic [1:0] PAD_12MA    = 2'h2;
  localparam logic [1:0] PAD_INVALID = 2'h3;

  // Self-test patterns and run length.
  localparam logic [11:0] CHECKER_A     = 12'ha5a;
  localparam logic [11:0] CHECKER_B     = 12'h5a5;
  localparam int          RUN_CYCLES    = 512;
  localparam logic [9:0]  RUN_LAST      = 10'(RUN_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } bpd_state_t;

  typedef struct packed {
    logic pattern;
    logic source;
    logic loop;
    logic start;
    logic on;
  } bpd_test_ctrl_t;

  typedef struct packed {
    logic dll_enable;
    logic tx_bandgap_off;
    logic tx_i_current_off;
    logic tx_q_current_off;
    logic clock_receiver_off;
    logic rx_converter_off;
    logic rx_q_core_off;
    logic rx_i_core_off;
  } bpd_power_main_t;

endpackage : bpd_pkg

/* rtl/bpd_sync.sv */
// Two-stage synchroniser for levels that arrive from outside the clock domain.
// Assumes the input is a quasi-static level; multi-bit buses may be sampled skewed by one cycle.
module bpd_sync
  import bpd_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and control
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : bpd_sync

/* rtl/bpd_regs.sv */
// Register bank for receive self-test, transmit signature read-back, power-down and pad drive.
// Assumes CLK_I is the serial-port clock that keeps running while the chip clocks are gated.
module bpd_regs
  import bpd_pkg::*;
#(
  // Arbitrary neutral value.
  parameter logic [7:0] REVISION_CODE = 8'h5a
) (
  // Clock, reset and clock enable
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CE_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Transmit signatures from the transmit self-test, same clock
  input  wire logic [15:0] TX_I_SIGNATURE_I,
  input  wire logic [15:0] TX_Q_SIGNATURE_I,
  // Regulator state from the analog side, asynchronous
  input  wire logic        DELAY_LOOP_REGULATOR_UP_I,
  input  wire logic        CLOCK_REGULATOR_UP_I,
  input  wire logic        RECEIVE_REGULATOR_UP_I,
  input  wire logic        RECEIVE_FLASH_REGULATOR_UP_I,
  input  wire logic        CORE_REGULATOR_UP_I,
  // Receive-path samples from the shared data pins, asynchronous
  input  wire logic [11:0] SHARED_DATA_PINS_I,
  // Power-down controls
  output logic             DLL_ENABLE_O,
  output logic             TX_BANDGAP_OFF_O,
  output logic             TX_I_CURRENT_OFF_O,
  output logic             TX_Q_CURRENT_OFF_O,
  output logic             CLOCK_RECEIVER_OFF_O,
  output logic             RX_CONVERTER_OFF_O,
  output logic             RX_Q_CORE_OFF_O,
  output logic             RX_I_CORE_OFF_O,
  output logic             DELAY_LOOP_REGULATOR_OFF_O,
  output logic             DELAY_LOOP_BIAS_OFF_O,
  output logic             CLOCK_REGULATOR_OFF_O,
  output logic             RECEIVE_REGULATOR_OFF_O,
  output logic             RECEIVE_FLASH_REGULATOR_OFF_O,
  output logic             AUX_CONVERTER_OFF_O,
  output logic             AUX_REFERENCE_OFF_O,
  output logic             REFERENCE_RESISTOR_SELECT_O,
  // Pad drive strength
  output logic      [1:0]  DATA_PAD_STRENGTH_O,
  output logic      [1:0]  IQ_SELECT_PAD_STRENGTH_O,
  // Receive self-test stream
  output logic      [11:0] RX_TEST_DATA_O,
  output logic             RX_TEST_VALID_O,
  output logic             RX_TEST_BUSY_O,
  output logic             RX_TEST_DONE_O
);

  // Storage.
  bpd_test_ctrl_t  test_ctrl_ff;
  bpd_power_main_t power_main_ff;
  logic [7:0]      power_regs_ff;
  logic            res_sel_ff;
  logic [7:0]      pad_drive_ff;
  logic [1:0]      data_pad_ff;
  logic [1:0]      iq_pad_ff;

  // Bus answer.
  logic [31:0]     prdata_ff;
  logic            pready_ff;
  logic            pslverr_ff;

  // Self-test engine.
  bpd_state_t      state_ff;
  bpd_state_t      nxt_state;
  logic            busy_ff;
  logic            done_ff;
  logic [9:0]      count_ff;
  logic [11:0]     lfsr_ff;
  logic            phase_ff;
  logic [15:0]     misr_ff;
  logic [11:0]     test_data_ff;
  logic            test_valid_ff;

  // Synchronised inputs.
  logic [4:0]      reg_up_sync;
  logic [11:0]     pins_sync;

  bpd_sync #(
    .WIDTH (5)
  ) u_reg_up_sync (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .ce_i    (CE_I),
    .async_i ({DELAY_LOOP_REGULATOR_UP_I, CLOCK_REGULATOR_UP_I, RECEIVE_REGULATOR_UP_I,
               RECEIVE_FLASH_REGULATOR_UP_I, CORE_REGULATOR_UP_I}),
    .sync_o  (reg_up_sync)
  );

  bpd_sync #(
    .WIDTH (12)
  ) u_pins_sync (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .ce_i    (CE_I),
    .async_i (SHARED_DATA_PINS_I),
    .sync_o  (pins_sync)
  );

  // Address decode. Misaligned or unlisted addresses answer with an error.
  wire [7:0] reg_idx    = PADDR_I[9:2];
  wire       addr_align = (PADDR_I[1:0] == 2'h0) && (PADDR_I[11:10] == 2'h0);
  wire       hit_ctrl   = addr_align && (reg_idx == IDX_RX_TEST_CTRL);
  wire       hit_pmain  = addr_align && (reg_idx == IDX_POWER_MAIN);
  wire       hit_pregs  = addr_align && (reg_idx == IDX_POWER_REGS);
  wire       hit_status = addr_align && (reg_idx == IDX_REG_STATUS);
  wire       hit_pad    = addr_align && (reg_idx == IDX_PAD_DRIVE);
  wire       hit_ro     = addr_align && ((reg_idx == IDX_TX_I_SIG_HIGH) || (reg_idx == IDX_TX_I_SIG_LOW) ||
                                         (reg_idx == IDX_TX_Q_SIG_HIGH) || (reg_idx == IDX_TX_Q_SIG_LOW) ||
                                         (reg_idx == IDX_HW_REVISION)   || (reg_idx == IDX_RX_SIG_HIGH) ||
                                         (reg_idx == IDX_RX_SIG_LOW)    || (reg_idx == IDX_RX_TEST_STAT));
  wire       hit_any    = hit_ctrl || hit_pmain || hit_pregs || hit_status || hit_pad || hit_ro;

  // The slave inserts one wait state so that read data comes from a flop.
  wire       access     = PSEL_I && PENABLE_I;
  wire       first_acc  = access && !pready_ff;
  wire       commit     = access && pready_ff;
  wire       wr_commit  = commit && PWRITE_I && PSTRB_I[0] && hit_any;
  wire [7:0] wbyte      = PWDATA_I[7:0];

  // Read multiplexer; unused bits are masked to zero.
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (1'b1)
      hit_ctrl:                         rd_byte = 8'(test_ctrl_ff) & RX_TEST_CTRL_MASK;
      reg_idx == IDX_TX_I_SIG_HIGH:     rd_byte = TX_I_SIGNATURE_I[15:8];
      reg_idx == IDX_TX_I_SIG_LOW:      rd_byte = TX_I_SIGNATURE_I[7:0];
      reg_idx == IDX_TX_Q_SIG_HIGH:     rd_byte = TX_Q_SIGNATURE_I[15:8];
      reg_idx == IDX_TX_Q_SIG_LOW:      rd_byte = TX_Q_SIGNATURE_I[7:0];
      reg_idx == IDX_HW_REVISION:       rd_byte = REVISION_CODE;
      hit_pmain:                        rd_byte = power_main_ff;
      hit_pregs:                        rd_byte = power_regs_ff & POWER_REGS_MASK;
      hit_status:                       rd_byte = {reg_up_sync, 2'h0, res_sel_ff};
      hit_pad:                          rd_byte = pad_drive_ff & PAD_DRIVE_MASK;
      reg_idx == IDX_RX_SIG_HIGH:       rd_byte = misr_ff[15:8];
      reg_idx == IDX_RX_SIG_LOW:        rd_byte = misr_ff[7:0];
      reg_idx == IDX_RX_TEST_STAT:      rd_byte = {6'h00, (state_ff == ST_DONE), (state_ff == ST_RUN)};
      default:                          rd_byte = 8'h00;
    endcase
  end

  wire [31:0] nxt_prdata = (first_acc && !PWRITE_I && hit_any) ? {24'h000000, rd_byte} : 32'h00000000;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (CE_I) begin
      pready_ff  <= first_acc;
      pslverr_ff <= first_acc && !hit_any;
      prdata_ff  <= nxt_prdata;
    end
  end

  // Writable registers. Signatures, revision and status bits have no write path,
  // so a write to them has nothing to change.
  wire [1:0] wr_data_pad = wbyte[DATA_PAD_LSB +: 2];
  wire [1:0] wr_iq_pad   = wbyte[IQ_PAD_LSB +: 2];

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      test_ctrl_ff  <= bpd_test_ctrl_t'(RX_TEST_CTRL_RST[4:0]);
      power_main_ff <= bpd_power_main_t'(POWER_MAIN_RST);
      power_regs_ff <= POWER_REGS_RST;
      res_sel_ff    <= RES_SEL_RST;
      pad_drive_ff  <= PAD_DRIVE_RST;
    end else if (CE_I && wr_commit) begin
      if (hit_ctrl) begin
        test_ctrl_ff <= bpd_test_ctrl_t'(wbyte[4:0]);
      end
      if (hit_pmain) begin
        power_main_ff <= bpd_power_main_t'(wbyte & POWER_MAIN_MASK);
      end
      if (hit_pregs) begin
        power_regs_ff <= wbyte & POWER_REGS_MASK;
      end
      if (hit_status) begin
        res_sel_ff <= wbyte[RES_SEL_BIT];
      end
      if (hit_pad) begin
        pad_drive_ff <= wbyte & PAD_DRIVE_MASK;
      end
    end
  end

  // An invalid pad code is stored for read-back but never reaches the pads:
  // the pads keep the last valid strength rather than an undefined drive.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      data_pad_ff <= PAD_DRIVE_RST[DATA_PAD_LSB +: 2];
      iq_pad_ff   <= PAD_DRIVE_RST[IQ_PAD_LSB +: 2];
    end else if (CE_I && wr_commit && hit_pad) begin
      if (wr_data_pad != PAD_INVALID) begin
        data_pad_ff <= wr_data_pad;
      end
      if (wr_iq_pad != PAD_INVALID) begin
        iq_pad_ff <= wr_iq_pad;
      end
    end
  end

  // Receive self-test engine. Its clock is gated by the clock receiver, so it
  // is held idle while that receiver is off; the register port keeps running.
  wire        engine_go  = test_ctrl_ff.on && test_ctrl_ff.start &&
                           !power_main_ff.clock_receiver_off;
  wire        run_end    = !test_ctrl_ff.loop && (count_ff == RUN_LAST);
  wire [11:0] chk_word   = phase_ff ? CHECKER_B : CHECKER_A;
  wire [11:0] gen_word   = test_ctrl_ff.pattern ? lfsr_ff : chk_word;
  wire [11:0] test_word  = test_ctrl_ff.source ? pins_sync : gen_word;
  wire        lfsr_fb    = lfsr_ff[11] ^ lfsr_ff[5] ^ lfsr_ff[3] ^ lfsr_ff[0];
  wire [11:0] nxt_lfsr   = {lfsr_ff[10:0], lfsr_fb};
  wire        misr_fb    = misr_ff[15] ^ misr_ff[14] ^ misr_ff[12] ^ misr_ff[3];
  wire [15:0] nxt_misr   = {misr_ff[14:0], misr_fb} ^ {4'h0, test_word};
  wire        running    = (state_ff == ST_RUN) && engine_go;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (engine_go) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!engine_go) begin
          nxt_state = ST_IDLE;
        end else if (run_end) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!engine_go) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_ff <= ST_IDLE;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else if (CE_I) begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state == ST_RUN);
      done_ff  <= (nxt_state == ST_DONE);
    end
  end

  // Counters and pattern sources restart on every start from idle, so each
  // fixed run produces a repeatable signature.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      count_ff <= 10'h000;
      lfsr_ff  <= LFSR_SEED;
      phase_ff <= 1'b0;
      misr_ff  <= MISR_SEED;
    end else if (CE_I) begin
      if (state_ff == ST_IDLE && engine_go) begin
        count_ff <= 10'h000;
        lfsr_ff  <= LFSR_SEED;
        phase_ff <= 1'b0;
        misr_ff  <= MISR_SEED;
      end else if (running) begin
        count_ff <= count_ff + 10'h001;
        lfsr_ff  <= nxt_lfsr;
        phase_ff <= !phase_ff;
        misr_ff  <= nxt_misr;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      test_data_ff  <= 12'h000;
      test_valid_ff <= 1'b0;
    end else if (CE_I) begin
      test_data_ff  <= running ? test_word : 12'h000;
      test_valid_ff <= running;
    end
  end

  // Outputs.
  assign PRDATA_O                      = prdata_ff;
  assign PREADY_O                      = pready_ff;
  assign PSLVERR_O                     = pslverr_ff;
  assign DLL_ENABLE_O                  = power_main_ff.dll_enable;
  assign TX_BANDGAP_OFF_O              = power_main_ff.tx_bandgap_off;
  assign TX_I_CURRENT_OFF_O            = power_main_ff.tx_i_current_off;
  assign TX_Q_CURRENT_OFF_O            = power_main_ff.tx_q_current_off;
  assign CLOCK_RECEIVER_OFF_O          = power_main_ff.clock_receiver_off;
  assign RX_CONVERTER_OFF_O            = power_main_ff.rx_converter_off;
  assign RX_Q_CORE_OFF_O               = power_main_ff.rx_q_core_off;
  assign RX_I_CORE_OFF_O               = power_main_ff.rx_i_core_off;
  assign DELAY_LOOP_REGULATOR_OFF_O    = power_regs_ff[6];
  assign DELAY_LOOP_BIAS_OFF_O         = power_regs_ff[5];
  assign CLOCK_REGULATOR_OFF_O         = power_regs_ff[4];
  assign RECEIVE_REGULATOR_OFF_O       = power_regs_ff[3];
  assign RECEIVE_FLASH_REGULATOR_OFF_O = power_regs_ff[2];
  assign AUX_CONVERTER_OFF_O           = power_regs_ff[1];
  assign AUX_REFERENCE_OFF_O           = power_regs_ff[0];
  assign REFERENCE_RESISTOR_SELECT_O   = res_sel_ff;
  assign DATA_PAD_STRENGTH_O           = data_pad_ff;
  assign IQ_SELECT_PAD_STRENGTH_O      = iq_pad_ff;
  assign RX_TEST_DATA_O                = test_data_ff;
  assign RX_TEST_VALID_O               = test_valid_ff;
  assign RX_TEST_BUSY_O                = busy_ff;
  assign RX_TEST_DONE_O                = done_ff;

endmodule : bpd_regs

/* verif/bpd_regs_props.sv */
// Checker for the self-test and power register bank: APB answer shape and self-test states.
// Assumes it is bound to bpd_regs and sees only that module's ports.
module bpd_regs_props
  import bpd_pkg::*;
#(
  // Arbitrary neutral value; the bind hands over the design's own.
  parameter logic [7:0] REVISION_CODE = 8'h5a
) (
  // Clock, reset and bus
  input wire logic        CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // Block side
  input wire logic [15:0] TX_I_SIGNATURE_I,
  input wire logic        CLOCK_RECEIVER_OFF_O,
  input wire logic        RX_TEST_VALID_O,
  input wire logic        RX_TEST_BUSY_O,
  input wire logic        RX_TEST_DONE_O
);
  logic [10:0] run_cnt_ff;
  logic [10:0] nxt_run_cnt;
  wire         rd_ans;

  // Counts busy cycles so the fixed run length can be checked without a long repetition.
  assign nxt_run_cnt = RX_TEST_BUSY_O ? run_cnt_ff + 11'h1 : 11'h0;
  assign rd_ans      = PREADY_O && !PWRITE_I;
  always_ff @(posedge CLK_I) begin
    run_cnt_ff <= SYS_RST_I ? 11'h0 : nxt_run_cnt;
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_one_wait: assert property (PSEL_I && !PENABLE_I |=> !PREADY_O ##1 PREADY_O)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY_O |-> PSEL_I && PENABLE_I ##1 !PREADY_O)
    else $error("ready outside access or longer than one cycle");
  a_idle_data: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data not zero outside answer");
  a_err_shape: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
    else $error("error answer malformed");
  a_rev_read: assert property (rd_ans && PADDR_I == {2'b00, IDX_HW_REVISION, 2'b00}
    |-> PRDATA_O == {24'h0, REVISION_CODE} && !PSLVERR_O) else $error("revision read wrong");
  a_sig_read: assert property (rd_ans && PADDR_I == {2'b00, IDX_TX_I_SIG_HIGH, 2'b00}
    |-> {PRDATA_O[7:0], 8'h00} == ($past(TX_I_SIGNATURE_I) & 16'hff00)) else $error("signature read wrong");
  a_busy_done: assert property (RX_TEST_BUSY_O |-> !RX_TEST_DONE_O)
    else $error("busy and done together");
  a_valid_start: assert property ($rose(RX_TEST_BUSY_O) |=> RX_TEST_VALID_O)
    else $error("no valid word after start");
  a_clk_off_idle: assert property (CLOCK_RECEIVER_OFF_O |=> !RX_TEST_BUSY_O && !RX_TEST_DONE_O)
    else $error("engine not idle with clock receiver off");
  a_run_length: assert property ($rose(RX_TEST_DONE_O) |-> run_cnt_ff == 11'(RUN_CYCLES))
    else $error("fixed run length wrong");
endmodule : bpd_regs_props

bind bpd_regs bpd_regs_props #(.REVISION_CODE(REVISION_CODE)) i_props (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .TX_I_SIGNATURE_I(TX_I_SIGNATURE_I), .CLOCK_RECEIVER_OFF_O(CLOCK_RECEIVER_OFF_O),
  .RX_TEST_VALID_O(RX_TEST_VALID_O), .RX_TEST_BUSY_O(RX_TEST_BUSY_O), .RX_TEST_DONE_O(RX_TEST_DONE_O));

/* verif/tb.sv */
// Self-checking bench for the register bank: APB access, status, pad drive and receive self-test.
// Assumes one wait state per APB access as the design's hand-over describes.
module tb
  import bpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary revision code for this bench.
  localparam logic [7:0] REV = 8'h3c;
  `define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h0, pins = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0]  pstrb = 4'h0;
  logic        ce = 1'b1;
  logic [15:0] sig_i = 16'h0, sig_q = 16'h0;
  logic [4:0]  reg_up = 5'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, res_sel, t_valid, t_busy, t_done;
  wire  [7:0]  pm;
  wire  [6:0]  pr;
  wire  [1:0]  pad_d, pad_q;
  wire  [11:0] t_data;
  int          bad_count = 0, checks_done = 0;

  always #2.5 clk = ~clk;

  bpd_regs #(.REVISION_CODE(REV)) i_dut (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TX_I_SIGNATURE_I(sig_i), .TX_Q_SIGNATURE_I(sig_q),
    .DELAY_LOOP_REGULATOR_UP_I(reg_up[4]), .CLOCK_REGULATOR_UP_I(reg_up[3]), .RECEIVE_REGULATOR_UP_I(reg_up[2]),
    .RECEIVE_FLASH_REGULATOR_UP_I(reg_up[1]), .CORE_REGULATOR_UP_I(reg_up[0]), .SHARED_DATA_PINS_I(pins),
    .DLL_ENABLE_O(pm[7]), .TX_BANDGAP_OFF_O(pm[6]), .TX_I_CURRENT_OFF_O(pm[5]), .TX_Q_CURRENT_OFF_O(pm[4]),
    .CLOCK_RECEIVER_OFF_O(pm[3]), .RX_CONVERTER_OFF_O(pm[2]), .RX_Q_CORE_OFF_O(pm[1]), .RX_I_CORE_OFF_O(pm[0]),
    .DELAY_LOOP_REGULATOR_OFF_O(pr[6]), .DELAY_LOOP_BIAS_OFF_O(pr[5]), .CLOCK_REGULATOR_OFF_O(pr[4]),
    .RECEIVE_REGULATOR_OFF_O(pr[3]), .RECEIVE_FLASH_REGULATOR_OFF_O(pr[2]), .AUX_CONVERTER_OFF_O(pr[1]),
    .AUX_REFERENCE_OFF_O(pr[0]), .REFERENCE_RESISTOR_SELECT_O(res_sel), .DATA_PAD_STRENGTH_O(pad_d),
    .IQ_SELECT_PAD_STRENGTH_O(pad_q), .RX_TEST_DATA_O(t_data), .RX_TEST_VALID_O(t_valid),
    .RX_TEST_BUSY_O(t_busy), .RX_TEST_DONE_O(t_done));

  function automatic logic [31:0] stat_exp(input logic [4:0] up, input logic sel);
    return {24'h0, up, 2'b00, sel};
  endfunction : stat_exp

  // An invalid drive code must leave the pad at its last valid strength.
  function automatic logic [1:0] pad_exp(input logic [1:0] prev, input logic [1:0] code);
    return (code == 2'h3) ? prev : code;
  endfunction : pad_exp

  function automatic logic [11:0] lfsr_next(input logic [11:0] s);
    return {s[10:0], s[11] ^ s[5] ^ s[3] ^ s[0]};
  endfunction : lfsr_next

  // Signature of one fixed checkerboard run, folded word by word from the seed.
  function automatic logic [15:0] misr_exp();
    logic [15:0] m;
    m = MISR_SEED;
    for (int i = 0; i < RUN_CYCLES; i++) begin
      m = {m[14:0], m[15] ^ m[14] ^ m[12] ^ m[3]} ^ {4'h0, (i % 2 == 1) ? CHECKER_B : CHECKER_A};
    end
    return m;
  endfunction : misr_exp

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] strb);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= {24'($urandom()), d};
    pstrb  <= strb;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      bad_count++;
      $display("[FAIL] apb answer expected ready seen none");
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // The second edge lets what the write edge launched settle before callers look.
    repeat (2) @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hf);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, 4'h0);
    `CHK(nm, exp, rd)
  endtask : rd_chk

  task automatic wait_valid();
    int n;
    n = 0;
    while (t_valid !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    if (n >= 64) begin
      bad_count++;
      $display("[FAIL] test valid expected 1 seen 0");
    end
  endtask : wait_valid

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (12000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    logic [7:0]  d;
    logic [1:0]  pd;
    logic [1:0]  pq;
    logic [11:0] w;
    logic [15:0] sig;
    int          v;
    void'($urandom(32'h2e6c6c22));
    reg_up <= 5'($urandom());
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("ctrl rst", IDX_RX_TEST_CTRL, 32'h0);
    rd_chk("pwr0 rst", IDX_POWER_MAIN, 32'h0);
    rd_chk("pwr1 rst", IDX_POWER_REGS, 32'h0);
    rd_chk("status rst", IDX_REG_STATUS, stat_exp(reg_up, 1'b0));
    rd_chk("revision", IDX_HW_REVISION, {24'h0, REV});
    wr(IDX_HW_REVISION, ~REV);
    rd_chk("revision kept", IDX_HW_REVISION, {24'h0, REV});
    apb(1'b0, 8'h56, 8'h00, 4'h0);
    `CHK("unmapped err", 1'b1, err)
    for (int k = 0; k < 6; k++) begin
      sig_i  <= 16'($urandom());
      sig_q  <= 16'($urandom());
      reg_up <= 5'($urandom());
      d = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : 8'($urandom());
      wr(IDX_POWER_MAIN, d);
      `CHK("pwr0 pins", d, pm)
      rd_chk("pwr0", IDX_POWER_MAIN, {24'h0, d});
      wr(IDX_POWER_REGS, ~d);
      `CHK("pwr1 pins", ~d[6:0], pr)
      apb(1'b1, IDX_POWER_REGS, d, 4'he);
      rd_chk("pwr1", IDX_POWER_REGS, {24'h0, 1'b0, ~d[6:0]});
      wr(IDX_REG_STATUS, d);
      `CHK("res sel", d[0], res_sel)
      rd_chk("status", IDX_REG_STATUS, stat_exp(reg_up, d[0]));
      wr(IDX_TX_I_SIG_HIGH, d);
      rd_chk("sig i hi", IDX_TX_I_SIG_HIGH, {24'h0, sig_i[15:8]});
      rd_chk("sig i lo", IDX_TX_I_SIG_LOW, {24'h0, sig_i[7:0]});
      rd_chk("sig q hi", IDX_TX_Q_SIG_HIGH, {24'h0, sig_q[15:8]});
      rd_chk("sig q lo", IDX_TX_Q_SIG_LOW, {24'h0, sig_q[7:0]});
    end
    pd = PAD_4MA;
    pq = PAD_4MA;
    for (int c = 0; c < 4; c++) begin
      d = {2'(c), 2'(3 - c), 4'($urandom())};
      wr(IDX_PAD_DRIVE, d);
      pd = pad_exp(pd, d[7:6]);
      pq = pad_exp(pq, d[5:4]);
      `CHK("data pad", pd, pad_d)
      `CHK("iq pad", pq, pad_q)
      rd_chk("pad reg", IDX_PAD_DRIVE, {24'h0, d & PAD_DRIVE_MASK});
    end
    wr(IDX_POWER_MAIN, 8'h00);
    wr(IDX_RX_TEST_CTRL, 8'h03);
    v = 0;
    for (int n = 0; n < 1000 && t_done !== 1'b1; n++) begin
      @(posedge clk);
      if (t_valid === 1'b1 && v == 0) `CHK("word 0", CHECKER_A, t_data)
      if (t_valid === 1'b1 && v == 1) `CHK("word 1", CHECKER_B, t_data)
      if (t_valid === 1'b1) v++;
    end
    `CHK("valid count", RUN_CYCLES, v)
    rd_chk("test stat", IDX_RX_TEST_STAT, 32'h2);
    sig = misr_exp();
    rd_chk("rx sig hi", IDX_RX_SIG_HIGH, {24'h0, sig[15:8]});
    rd_chk("rx sig lo", IDX_RX_SIG_LOW, {24'h0, sig[7:0]});
    wr(IDX_RX_TEST_CTRL, 8'h01);
    `CHK("start clear", 2'b00, {t_busy, t_done})
    wr(IDX_RX_TEST_CTRL, 8'h07);
    repeat (600) @(posedge clk);
    `CHK("loop run", 2'b10, {t_busy, t_done})
    ce <= 1'b0;
    @(posedge clk);
    w = t_data;
    repeat (3) @(posedge clk);
    `CHK("ce freeze", w, t_data)
    ce <= 1'b1;
    wr(IDX_POWER_MAIN, 8'h08);
    `CHK("clock off", 1'b0, t_busy)
    wr(IDX_POWER_MAIN, 8'h00);
    wr(IDX_RX_TEST_CTRL, 8'h00);
    wr(IDX_RX_TEST_CTRL, 8'h02);
    `CHK("no enable", 1'b0, t_busy)
    pins <= 12'($urandom());
    wr(IDX_RX_TEST_CTRL, 8'h00);
    wr(IDX_RX_TEST_CTRL, 8'h0f);
    repeat (4) @(posedge clk);
    `CHK("ext source", pins, t_data)
    wr(IDX_RX_TEST_CTRL, 8'h00);
    wr(IDX_RX_TEST_CTRL, 8'h13);
    wait_valid();
    w = t_data;
    `CHK("prn seed", LFSR_SEED, w)
    @(posedge clk);
    `CHK("prn step", lfsr_next(w), t_data)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("second reset", 14'h0, {pad_d, pad_q, res_sel, pr, t_busy, t_done})
    print_verdict();
  end
endmodule : tb
